// ==== verilog/channel_level_interrupt_gating.sv ====
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "chan_irq_consts.svh"
// How it works
// R1 - Register at 0x60 holds master enables of channels 5 to 0 in bits 5:0.
// R2 - Register at 0xE0 holds master enables of channels 11 to 6 in bits 5:0.
// R3 - Every enable bit is written and read back by the host.
// R4 - An enable of 0 blocks the channel, 1 opens it at channel level.
// R5 - A cleared master enable keeps all channel events off the interrupt.
// R6 - A set master enable lets any source-enabled event raise the interrupt.
// R7 - Software must also set source enables; master enable alone is silent.
// R8 - The interrupt is the OR over channels of master and gated events.
module channel_level_interrupt_gating #(
   parameter int CHANNELS = 12,
   parameter int SRC_W = `SRC_WIDTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // per-channel pending events and source enables
   input wire logic [CHANNELS*SRC_W-1:0] src_pending,
   input wire logic [CHANNELS*SRC_W-1:0] source_irq_enable_reg,
   // host interrupt
   output logic irq
);
   localparam int GRP = `IRQ_EN_GROUP_SIZE;
   typedef struct packed {
      chan_irq_pkg::bus_state_t st;
      logic [GRP-1:0] en_low;
      logic [GRP-1:0] en_high;
      logic [31:0] rdata;
      logic busy;
      logic irq;
   } state_t;
   state_t s;
   state_t next_s;
   logic [CHANNELS-1:0] chan_active;
   logic [CHANNELS-1:0] master_en;
   logic [CHANNELS*SRC_W-1:0] src_pend_s1;
   logic [CHANNELS*SRC_W-1:0] src_pend_s2;
   logic req;
   logic hit_low;
   logic hit_high;
   logic lane_ok;
   logic [GRP-1:0] wr_field;
   logic [31:0] rd_word;
   // ----------------------------------------
   // pending events come from outside: two flops
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         src_pend_s1 <= '0;
         src_pend_s2 <= '0;
      end else begin
         src_pend_s1 <= src_pending;
         src_pend_s2 <= src_pend_s1;
      end
   end
   // R4 enables per channel
   assign master_en = {s.en_high, s.en_low};
   // R7 source enables from outside
   chan_gate #(
      .CHANNELS(CHANNELS),
      .SRC_W(SRC_W)
   ) u_gate (
      .clk(clk),
      .reset_n(reset_n),
      .master_en(master_en),
      .src_en(source_irq_enable_reg),
      .src_pending(src_pend_s2),
      .chan_active(chan_active)
   );
   assign req = avs_read | avs_write;
   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // R1 low group address
   assign hit_low = (avs_address == `IRQ_EN_LOW_OFFSET);
   // R2 high group address
   assign hit_high = (avs_address == `IRQ_EN_HIGH_OFFSET);
   // writes need lane 0, where bits 5:0 sit
   assign lane_ok = avs_byteenable[0];
   // ----------------------------------------
   // write field and readback word
   // ----------------------------------------
   // R1 R2 only bits 5:0 are stored
   assign wr_field = avs_writedata[GRP-1:0];
   // R3 readback, unused bits read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit_low) begin
         rd_word[GRP-1:0] = s.en_low;
      end else if (hit_high) begin
         rd_word[GRP-1:0] = s.en_high;
      end
   end
   // ----------------------------------------
   // bus slave and interrupt
   // ----------------------------------------
   always_comb begin
      next_s = s;
      next_s.busy = 1'b1;
      // R8 or over channels
      next_s.irq = |chan_active;
      unique case (s.st)
         chan_irq_pkg::ST_IDLE: begin
            if (req) begin
               // one wait state, then the answer
               next_s.st = chan_irq_pkg::ST_DONE;
               next_s.busy = 1'b0;
               next_s.rdata = rd_word;
               // R1 R3 low group write
               if (avs_write && lane_ok && hit_low) begin
                  next_s.en_low = wr_field;
               end
               // R2 R3 high group write
               if (avs_write && lane_ok && hit_high) begin
                  next_s.en_high = wr_field;
               end
            end
         end
         chan_irq_pkg::ST_DONE: begin
            next_s.st = chan_irq_pkg::ST_IDLE;
         end
         default: begin
            next_s.st = chan_irq_pkg::ST_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s.st <= chan_irq_pkg::ST_IDLE;
         s.en_low <= `IRQ_EN_RESET;
         s.en_high <= `IRQ_EN_RESET;
         s.rdata <= 32'h0000_0000;
         s.busy <= 1'b1;
         s.irq <= 1'b0;
      end else begin
         s <= next_s;
      end
   end
   assign avs_readdata = s.rdata;
   // ----------------------------------------
   // outputs straight from the state flops
   // ----------------------------------------
   assign avs_waitrequest = s.busy;
   assign irq = s.irq;
endmodule
`default_nettype wire

// ==== inc/chan_irq_consts.svh ====
`ifndef CHAN_IRQ_CONSTS_SVH
`define CHAN_IRQ_CONSTS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define IRQ_EN_LOW_OFFSET 8'h60
`define IRQ_EN_HIGH_OFFSET 8'hE0
`define SRC_EN_BASE_OFFSET 8'h00
// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define IRQ_EN_FIELD_MSB 5
`define IRQ_EN_GROUP_SIZE 6
`define IRQ_EN_RESET 6'h00
`define SRC_EN_RESET 8'h00
`define ADDR_WIDTH 8
`define DATA_WIDTH 32
`define SRC_WIDTH 8
`endif

// ==== inc/chan_irq_pkg.sv ====
package chan_irq_pkg;
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avalon_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
      logic readdatavalid_unused;
   } avalon_rsp_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DONE = 2'b10
   } bus_state_t;
endpackage

// ==== verilog/chan_gate.sv ====
`timescale 1ns/10ps
`default_nettype none
// per-channel gating of pending events by source and master enables
module chan_gate #(
   parameter int CHANNELS = 12,
   parameter int SRC_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // enables and events
   input wire logic [CHANNELS-1:0] master_en,
   input wire logic [CHANNELS*SRC_W-1:0] src_en,
   input wire logic [CHANNELS*SRC_W-1:0] src_pending,
   // result
   output logic [CHANNELS-1:0] chan_active
);
   logic [CHANNELS-1:0] next_chan_active;
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         // R5 R6 R8 master and source gating
         assign next_chan_active[g] = master_en[g] &
            (|(src_en[g*SRC_W +: SRC_W] & src_pending[g*SRC_W +: SRC_W]));
      end
   endgenerate
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         chan_active <= '0;
      end else begin
         chan_active <= next_chan_active;
      end
   end
endmodule
`default_nettype wire

// ==== verification/chan_irq_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module chan_irq_sva #(parameter int CHANNELS = 12, parameter int SRC_W = 8) (
   input wire logic clk, reset_n, avs_read, avs_write, avs_waitrequest, irq,
   input wire logic [7:0] avs_address,
   input wire logic [31:0] avs_writedata, avs_readdata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [CHANNELS*SRC_W-1:0] src_pending, source_irq_enable_reg
);
   logic [CHANNELS-1:0] en, act;
   logic x;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // enables as software last wrote them
   always_ff @(posedge clk)
      if (!reset_n) en <= '0;
      else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
         if (avs_address == 8'h60) en[5:0] <= avs_writedata[5:0];
         if (avs_address == 8'hE0) en[11:6] <= avs_writedata[5:0];
      end
   always_comb
      for (int c = 0; c < CHANNELS; c++)
         act[c] = |(src_pending[c*SRC_W+:SRC_W]
            & source_irq_enable_reg[c*SRC_W+:SRC_W]);
   assign x = |(en & act);
   a_wait_once: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_low_read: assert property (
      avs_read && !avs_waitrequest && avs_address == 8'h60
      |-> avs_readdata == 32'(en[5:0])) else $error("low group readback");
   a_high_read: assert property (
      avs_read && !avs_waitrequest && avs_address == 8'hE0
      |-> avs_readdata == 32'(en[11:6])) else $error("high group readback");
   a_gap_read: assert property (
      avs_read && !avs_waitrequest && avs_address != 8'h60
      && avs_address != 8'hE0 |-> avs_readdata == '0)
      else $error("unmapped read not zero");
   a_irq_masked: assert property (
      (en == '0)[*5] |-> !irq) else $error("irq with channels masked");
   a_irq_raise: assert property (
      ($stable({src_pending, source_irq_enable_reg, en}) && x)[*5] |-> irq)
      else $error("enabled event missed");
   a_irq_match: assert property (
      $stable({src_pending, source_irq_enable_reg, en})[*5] |-> irq == x)
      else $error("irq differs from gated sum");
endmodule
bind channel_level_interrupt_gating chan_irq_sva #(.CHANNELS(CHANNELS),
   .SRC_W(SRC_W)) sva (.clk, .reset_n, .avs_read, .avs_write,
   .avs_waitrequest, .irq, .avs_address, .avs_writedata, .avs_readdata,
   .avs_byteenable, .src_pending, .source_irq_enable_reg);
`default_nettype wire

// ==== verification/host_irq_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_irq_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic irq,
   output logic [15:0] rises
);
   logic last;
   // host counts each new interrupt request
   always_ff @(posedge clk) begin
      last <= irq;
      if (!reset_n) rises <= '0;
      else if (irq && !last) rises <= rises + 16'h1;
   end
endmodule
`default_nettype wire

// ==== verification/channel_level_interrupt_gating_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module channel_level_interrupt_gating_bench;
   logic clk = 0, reset_n = 0, rd = 0, wr = 0, irq, wt;
   logic [7:0] ad = 0;
   logic [31:0] wd = 0, rdat, q;
   logic [3:0] be = 0;
   logic [95:0] pend = 0, sen = 0;
   logic [11:0] en = 0, act;
   logic [15:0] rises;
   int seed = 32'hfcf2, failures = 0, checked = 0;
   always #20 clk = ~clk;
   channel_level_interrupt_gating dut (.clk, .reset_n, .avs_address(ad),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt),
      .src_pending(pend), .source_irq_enable_reg(sen), .irq);
   host_irq_model host (.clk, .reset_n, .irq, .rises);
   function logic [31:0] r;
      return $random(seed);
   endfunction
   task wrap_up;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] g, e);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      rd <= !w; wr <= w; ad <= a; wd <= d;
      do @(posedge clk); while (wt !== 1'b0);
      q = rdat;
      rd <= 0; wr <= 0;
      if (w && be[0] && a == 8'h60) en[5:0] = d[5:0];
      if (w && be[0] && a == 8'hE0) en[11:6] = d[5:0];
      @(posedge clk);
   endtask
   task step(input logic [31:0] lo, hi, input logic [95:0] p, s);
      bus(1, 8'(r()), '1);
      bus(1, 8'h60, lo);
      bus(1, 8'hE0, hi);
      pend <= p; sen <= s;
      repeat (6) @(posedge clk);
      for (int c = 0; c < 12; c++) act[c] = |(pend[c*8+:8] & sen[c*8+:8]);
      chk(32'(irq), 32'(|(en & act)));
      bus(0, 8'h60, 0); chk(q, 32'(en[5:0]));
      bus(0, 8'hE0, 0); chk(q, 32'(en[11:6]));
      bus(0, 8'(r()), 0); if (ad != 8'h60 && ad != 8'hE0) chk(q, 0);
   endtask
   initial begin
      #200000;
      failures++;
      wrap_up;
   end
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1;
      @(posedge clk);
      be <= 4'hF;
      step(0, 0, '1, '1);
      step('1, '1, '1, 0);
      step(0, 32'h20, 96'h1 << 95, 96'h1 << 95);
      for (int i = 0; i < 30; i++) begin
         be <= 4'(r());
         step(r() & r() & r(), r() & r() & r(), {r(), r(), r()},
            {r(), r(), r()} & {r(), r(), r()});
      end
      chk(32'(rises != 0), 1);
      wrap_up;
   end
endmodule
`default_nettype wire
